/* fps_defs.svh */
// register offsets, field positions, reset values and counts of the fifo pointer block
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
`define FPS_ADDR_EVENT_FLAGS_0      8'h06
`define FPS_ADDR_SYNC_CONTROL       8'h10
`define FPS_ADDR_PORT_A_FIFO_CTRL   8'h17
`define FPS_ADDR_FIFO_LEVEL         8'h18
`define FPS_ADDR_PORT_B_FIFO_CTRL   8'h19
`define FPS_EVT_ALIGNED_BIT         2
`define FPS_SYNC_RD_EN_BIT          7
`define FPS_SYNC_MODE_BIT           6
`define FPS_SYNC_EDGE_BIT           3
`define FPS_CTRL_OFFSET_MSB         2
`define FPS_CTRL_REQ_BIT            3
`define FPS_CTRL_ACK_BIT            4
`define FPS_CTRL_WARN_BIT           7
`define FPS_SYNC_CONTROL_RESET      8'h00
`define FPS_CTRL_RESET              4'h0
`define FPS_PLL_SYNC_DIVIDE         64
`define FPS_LEVEL_NEAR_EMPTY        3'h1
`define FPS_LEVEL_NEAR_FULL         3'h7
`define FPS_FRAME_PERIODS_DUAL      2'h1
`define FPS_FRAME_PERIODS_SINGLE    2'h2
`endif

/* fps_pkg.sv */
// types shared by the fifo pointer block
`default_nettype none
package fps_pkg;
    typedef logic [7:0] fps_reg_t;
    typedef logic [2:0] fps_ptr_t;
    typedef enum logic {FPS_SYNC_DATA_RATE, FPS_SYNC_FIFO_RATE} fps_sync_mode_t;
endpackage : fps_pkg
`default_nettype wire

/* fps_fifo_pointer_sync.sv */
// two input fifos with read/write pointer synchronisation, manual reset and level reporting
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"

// Behaviour
// - read-sync enable bit makes reference sync input reset the read pointer.
// - frame marker counts as reset on the first or second strobe rising edge seen while it is high.
// - in both sync modes the reference sync event forces the read pointer to zero.
// - a sync control bit chooses which reference sync transition is used.
// - with the clock multiplier on, read pointer resets every 64th reference edge.
// - sync-mode bit 0 selects data rate, 1 selects fifo rate synchronisation.
// - data rate mode loads write pointer with offset when read pointer next reaches zero.
// - fifo rate mode loads write pointer immediately with offset as absolute address.
// - read-sync disabled means read pointer never resets; write resets by frame or register.
// - without sync only data rate reset is safe; pointer spacing must stay above two.
// - device sets the acknowledge bit when it sees a manual reset request.
// - finished manual reset sets aligned event flag and clears that port's acknowledge.
// - with one shared strobe only the port A frame marker resets both fifos.
// - warning bit set when fifo level is one or seven.
// - level register shows write minus read as a seven bit thermometer code.
// - reported level may be off by one; keep two entries between pointers.
// - each port owns a 32-bit wide, 8-word deep fifo.
// - write pointer steps per word written, read pointer per data-rate read tick.
// - fifo should be kept near half full, pointer difference of four.
module fps_fifo_pointer_sync #(
    parameter int WORD_W       = 32,
    parameter int DEPTH        = 8,
    parameter int INTERP_RATIO = 2
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              input_data_strobe,
    input  wire logic              port_b_data_strobe,
    input  wire logic              port_a_frame_marker,
    input  wire logic              port_b_frame_marker,
    input  wire logic              reference_sync_input,
    input  wire logic [WORD_W-1:0] port_a_data,
    input  wire logic [WORD_W-1:0] port_b_data,
    input  wire logic              pll_enable,
    input  wire logic              single_strobe,
    input  wire logic              frame_two_periods,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire fps_pkg::fps_reg_t reg_wdata,
    output var  fps_pkg::fps_reg_t reg_rdata,
    output var  logic [WORD_W-1:0] port_a_dout,
    output var  logic [WORD_W-1:0] port_b_dout,
    output var  logic              dout_valid,
    output var  logic              fifo_warning
);
    import fps_pkg::*;

    localparam int NPIN  = 5;

    // pin synchronisers: three stages, value accepted once stages two and three agree
    logic [NPIN-1:0]     pin_s1;
    logic [NPIN-1:0]     pin_s2;
    logic [NPIN-1:0]     pin_s3;
    logic [NPIN-1:0]     pin_filt;
    logic [NPIN-1:0]     pin_prev;
    logic [2*WORD_W-1:0] dat_s1;
    logic [2*WORD_W-1:0] dat_s2;
    logic [2*WORD_W-1:0] dat_s3;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            dat_s1 <= '0;
            dat_s2 <= '0;
            dat_s3 <= '0;
        end else begin
            pin_s1 <= {reference_sync_input, port_b_frame_marker, port_a_frame_marker,
                       port_b_data_strobe, input_data_strobe};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            dat_s1 <= {port_b_data, port_a_data};
            dat_s2 <= dat_s1;
            dat_s3 <= dat_s2;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_filt <= '0;
            pin_prev <= '0;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_filt[i] <= pin_s3[i];
                end
            end
            pin_prev <= pin_filt;
        end
    end

    // registers
    fps_reg_t       sync_control;
    logic [3:0]     port_ctrl [2];
    logic [1:0]     ack;
    logic [1:0]     aligned_set;
    logic           aligned_flag;
    fps_ptr_t       level [2];
    logic [1:0]     warn;
    fps_sync_mode_t sync_mode;
    logic           rd_sync_en;

    assign rd_sync_en = sync_control[`FPS_SYNC_RD_EN_BIT];
    assign sync_mode  = sync_control[`FPS_SYNC_MODE_BIT] ? FPS_SYNC_FIFO_RATE : FPS_SYNC_DATA_RATE;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_control <= `FPS_SYNC_CONTROL_RESET;
            port_ctrl[0] <= `FPS_CTRL_RESET;
            port_ctrl[1] <= `FPS_CTRL_RESET;
        end else if (reg_wr_en) begin
            unique case (reg_addr)
                `FPS_ADDR_SYNC_CONTROL:     sync_control <= reg_wdata;
                `FPS_ADDR_PORT_A_FIFO_CTRL: port_ctrl[0] <= reg_wdata[3:0];
                `FPS_ADDR_PORT_B_FIFO_CTRL: port_ctrl[1] <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // aligned flag: write one to clear, a completion in the same cycle keeps it set
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aligned_flag <= 1'b0;
        end else if (|aligned_set) begin
            aligned_flag <= 1'b1;
        end else if (reg_wr_en && reg_addr == `FPS_ADDR_EVENT_FLAGS_0
                     && reg_wdata[`FPS_EVT_ALIGNED_BIT]) begin
            aligned_flag <= 1'b0;
        end
    end

    // level as thermometer code; the phase between strobe and read tick can skew it by one
    function automatic fps_reg_t therm(input fps_ptr_t lvl);
        fps_reg_t t;
        t = '0;
        for (int i = 0; i < 7; i++) begin
            t[i] = (3'(i) < lvl);
        end
        return t;
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd_en) begin
            unique case (reg_addr)
                `FPS_ADDR_EVENT_FLAGS_0:    reg_rdata <= {5'h00, aligned_flag, 2'h0};
                `FPS_ADDR_SYNC_CONTROL:     reg_rdata <= sync_control;
                `FPS_ADDR_PORT_A_FIFO_CTRL: reg_rdata <= {warn[0], 2'h0, ack[0], port_ctrl[0]};
                `FPS_ADDR_FIFO_LEVEL:       reg_rdata <= therm(level[0]);
                `FPS_ADDR_PORT_B_FIFO_CTRL: reg_rdata <= {warn[1], 2'h0, ack[1], port_ctrl[1]};
                default:                    reg_rdata <= '0;
            endcase
        end
    end

    assign fifo_warning = |warn;

    // data rate tick: converter clock divided by the interpolation ratio
    logic [$clog2(INTERP_RATIO+1)-1:0] div_cnt;
    logic                              rd_tick;

    assign rd_tick = (div_cnt == '0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else if (rd_tick) begin
            div_cnt <= ($bits(div_cnt))'(INTERP_RATIO - 1);
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    // reference sync event, edge chosen by software, every 64th edge with the multiplier
    logic ref_edge;
    logic ref_evt;
    logic [5:0] pll_cnt;

    assign ref_edge = sync_control[`FPS_SYNC_EDGE_BIT] ? (pin_prev[4] & ~pin_filt[4])
                                                       : (~pin_prev[4] & pin_filt[4]);
    assign ref_evt  = rd_sync_en && ref_edge
                      && (!pll_enable || pll_cnt == 6'(`FPS_PLL_SYNC_DIVIDE - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_cnt <= '0;
        end else if (ref_edge) begin
            pll_cnt <= pll_cnt + 1'b1;
        end
    end

    // read pointer is common to both fifos
    fps_ptr_t rd_ptr;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= '0;
        end else if (ref_evt) begin
            rd_ptr <= '0;
        end else if (rd_tick) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dout_valid <= 1'b0;
        end else begin
            dout_valid <= rd_tick;
        end
    end

    logic [WORD_W-1:0] rd_word [2];
    assign port_a_dout = rd_word[0];
    assign port_b_dout = rd_word[1];

    // per-port write side
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [WORD_W-1:0] mem [DEPTH];
        fps_ptr_t          wr_ptr;
        logic              strobe_rise;
        logic              frame_hi;
        logic [1:0]        frame_cnt;
        logic [1:0]        frame_need;
        logic              frame_qual;
        logic              dr_pend;
        logic              req_prev;
        logic              man_pend;
        logic              man_load;
        logic              dr_load;
        fps_ptr_t          offset;

        // a shared strobe also means port A's frame marker drives both fifos
        localparam int SP = (p == 0) ? 0 : 1;
        assign strobe_rise = single_strobe ? (pin_filt[0] & ~pin_prev[0])
                                           : (pin_filt[SP] & ~pin_prev[SP]);
        assign frame_hi    = single_strobe ? pin_filt[2] : pin_filt[2+p];
        assign frame_need  = frame_two_periods ? `FPS_FRAME_PERIODS_SINGLE : `FPS_FRAME_PERIODS_DUAL;
        assign frame_qual  = frame_hi && strobe_rise && (frame_cnt + 2'h1 == frame_need);
        assign offset      = port_ctrl[p][`FPS_CTRL_OFFSET_MSB:0];
        assign dr_load     = dr_pend && rd_tick && rd_ptr == '0;
        assign man_load    = man_pend && rd_tick && !dr_load;

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                frame_cnt <= '0;
            end else if (!frame_hi) begin
                frame_cnt <= '0;
            end else if (strobe_rise && frame_cnt != frame_need) begin
                frame_cnt <= frame_cnt + 2'h1;
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                dr_pend <= 1'b0;
            end else if (frame_qual && sync_mode == FPS_SYNC_DATA_RATE) begin
                dr_pend <= 1'b1;
            end else if (dr_load || (frame_qual && sync_mode == FPS_SYNC_FIFO_RATE)) begin
                dr_pend <= 1'b0;
            end
        end

        // manual reset: acknowledged on request, performed once software withdraws it
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                req_prev <= 1'b0;
                ack[p]   <= 1'b0;
                man_pend <= 1'b0;
            end else begin
                req_prev <= port_ctrl[p][`FPS_CTRL_REQ_BIT];
                if (port_ctrl[p][`FPS_CTRL_REQ_BIT] && !req_prev) begin
                    ack[p] <= 1'b1;
                end else if (man_load) begin
                    ack[p] <= 1'b0;
                end
                if (!port_ctrl[p][`FPS_CTRL_REQ_BIT] && req_prev && ack[p]) begin
                    man_pend <= 1'b1;
                end else if (man_load) begin
                    man_pend <= 1'b0;
                end
            end
        end

        assign aligned_set[p] = man_load;

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                wr_ptr <= '0;
            end else if (frame_qual && sync_mode == FPS_SYNC_FIFO_RATE) begin
                wr_ptr <= offset;
            end else if (dr_load) begin
                wr_ptr <= offset;
            end else if (man_load) begin
                wr_ptr <= rd_ptr + offset;
            end else if (strobe_rise) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end

        // storage writes keep going during a pointer load; only the pointer jumps
        always_ff @(posedge clk_sys) begin
            if (strobe_rise) begin
                mem[wr_ptr] <= dat_s3[p*WORD_W +: WORD_W];
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                rd_word[p] <= '0;
            end else if (rd_tick) begin
                rd_word[p] <= mem[rd_ptr];
            end
        end

        assign level[p] = wr_ptr - rd_ptr;

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                warn[p] <= 1'b0;
            end else begin
                warn[p] <= (level[p] == `FPS_LEVEL_NEAR_EMPTY) || (level[p] == `FPS_LEVEL_NEAR_FULL);
            end
        end
    end

endmodule : fps_fifo_pointer_sync
`default_nettype wire

/* fps_fifo_pointer_sync_assertions.sv */
// concurrent checks on the register port and read tick output of the fifo pointer block
`timescale 1ns/1ps
`default_nettype none
module fps_fifo_pointer_sync_assertions #(
    parameter int INTERP_RATIO = 2
) (
    input wire logic              clk_sys,
    input wire logic              rst_n,
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [7:0]        reg_addr,
    input wire fps_pkg::fps_reg_t reg_wdata,
    input wire fps_pkg::fps_reg_t reg_rdata,
    input wire logic              dout_valid
);
    import fps_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [3:0] gap;
    logic       seen;
    logic       req_a;
    logic       mapped;
    assign mapped = reg_addr inside {8'h06, 8'h10, 8'h17, 8'h18, 8'h19};
    // cycles since the last read word; checked only once the first word has shown
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap  <= 4'h0;
            seen <= 1'b0;
        end else begin
            gap  <= dout_valid ? 4'h0 : gap + 4'h1;
            seen <= seen | dout_valid;
        end
    end
    // shadow of the port a request bit, so only a 0 to 1 change expects an acknowledge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_a <= 1'b0;
        end else if (reg_wr_en && reg_addr == 8'h17) begin
            req_a <= reg_wdata[3];
        end
    end
    chk_sync_readback: assert property (
        reg_wr_en && reg_addr == 8'h10 ##1 !reg_wr_en ##1 reg_rd_en && reg_addr == 8'h10 ##1 !reg_rd_en
        |=> reg_rdata == $past(reg_wdata, 4)) else $error("sync control reads back wrong");
    chk_ctrl_readback: assert property (
        reg_wr_en && reg_addr inside {8'h17, 8'h19} ##1 !reg_wr_en ##1 reg_rd_en && reg_addr == $past(reg_addr, 2)
        ##1 !reg_rd_en |=> ((reg_rdata ^ $past(reg_wdata, 4)) & 8'h0F) == 8'h00) else $error("offset or request lost");
    chk_ack_raised: assert property (
        reg_wr_en && reg_addr == 8'h17 && reg_wdata[3] && !req_a ##1 !reg_wr_en ##1 reg_rd_en && reg_addr == 8'h17
        ##1 !reg_rd_en |=> reg_rdata[4]) else $error("request not acknowledged");
    chk_level_thermo: assert property (
        reg_rd_en && reg_addr == 8'h18 ##1 !reg_rd_en
        |=> !reg_rdata[7] && (reg_rdata & (reg_rdata + 8'h01)) == 8'h00) else $error("level not a thermometer code");
    chk_tick_cadence: assert property (
        seen |-> dout_valid == (gap == 4'(INTERP_RATIO - 1))) else $error("read tick spacing wrong");
    chk_unmapped_zero: assert property (
        reg_rd_en && !mapped ##1 !reg_rd_en |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    chk_ctrl_reserved: assert property (
        reg_rd_en && reg_addr inside {8'h17, 8'h19} ##1 !reg_rd_en |=> reg_rdata[6:5] == 2'b00)
        else $error("unused control bits set");
    chk_rdata_hold: assert property (
        !reg_rd_en && !$past(reg_rd_en) |=> $stable(reg_rdata)) else $error("read data moved without a read");
endmodule : fps_fifo_pointer_sync_assertions
`default_nettype wire

/* fps_source.sv */
// behavioural data source: strobe, counting data words and frame marker for one port
`timescale 1ns/1ps
`default_nettype none
module fps_source #(
    parameter int WORD_W = 32
) (
    input  wire logic              run,
    input  wire logic              frame_req,
    input  wire logic              two_periods,
    output var  logic              strobe,
    output var  logic              frame,
    output var  logic [WORD_W-1:0] data
);
    int   left;
    logic prev;
    // strobe period 40 ns matches one read tick at a ratio of 4; data and frame move on the fall
    initial begin
        strobe = 1'b0;
        frame  = 1'b0;
        data   = '0;
        left   = 0;
        prev   = 1'b0;
        #3;
        forever begin
            #20;
            if (!run) begin
                strobe = 1'b0;
                frame  = 1'b0;
                data   = ~data;
            end else if (strobe) begin
                strobe = 1'b0;
                data   = data + 1'b1;
                if (left > 0) left = left - 1;
                if (left == 0) frame = 1'b0;
                if (frame_req && !prev) begin
                    frame = 1'b1;
                    left  = two_periods ? 3 : 2;
                end
                prev = frame_req;
            end else begin
                strobe = 1'b1;
            end
        end
    end
endmodule : fps_source
`default_nettype wire

/* fps_fifo_pointer_sync_tb.sv */
// self-checking testbench of the fifo pointer block
`timescale 1ns/1ps
`default_nettype none
module fps_fifo_pointer_sync_tb;
    import fps_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst_n   = 1'b0;
    logic       stb_a, stb_b, frm_a, frm_b, run_a, run_b, req_a, req_b;
    logic       ref_sync, pll_en, single, two_per, wr_en, rd_en, warn;
    logic [7:0] addr;
    fps_reg_t   wdata, rdata, got;
    logic [31:0] dat_a, dat_b;
    logic [31:0] dout_a, dout_b, wa, wb, xa, xb;
    logic       dv;
    int         error_cnt = 0;
    int         total_checks = 0;
    int         k, n;
    logic [7:0] rst_tab [7] = '{8'h06, 8'h10, 8'h17, 8'h19, 8'h05, 8'hFF, 8'h11};
    logic [7:0] ctl [2] = '{8'h17, 8'h19};
    always #5 clk_sys = ~clk_sys;
    fps_fifo_pointer_sync #(.INTERP_RATIO(4)) fps_fifo_pointer_sync_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .input_data_strobe(stb_a), .port_b_data_strobe(stb_b),
        .port_a_frame_marker(frm_a), .port_b_frame_marker(frm_b), .reference_sync_input(ref_sync),
        .port_a_data(dat_a), .port_b_data(dat_b), .pll_enable(pll_en), .single_strobe(single),
        .frame_two_periods(two_per), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .port_a_dout(dout_a), .port_b_dout(dout_b), .dout_valid(dv), .fifo_warning(warn));
    fps_source fps_source_i (.run(run_a), .frame_req(req_a), .two_periods(two_per), .strobe(stb_a),
        .frame(frm_a), .data(dat_a));
    fps_source fps_source_b_i (.run(run_b), .frame_req(req_b), .two_periods(two_per), .strobe(stb_b),
        .frame(frm_b), .data(dat_b));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // takes both read words while the one-cycle valid pulse stands, then lets that pulse pass
    task automatic stream(output logic [31:0] a, output logic [31:0] b);
        n = 0;
        while (dv !== 1'b1 && n < 10) begin
            @(negedge clk_sys);
            n++;
        end
        check(8'(n < 10), 8'h01);
        a = dout_a;
        b = dout_b;
        @(negedge clk_sys);
    endtask : stream
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clk_sys);
        wr_en = 1'b0;
    endtask : wr
    // the value is taken two falls later so it is settled whichever edge loads it
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        rd_en = 1'b1;
        addr  = a;
        @(negedge clk_sys);
        rd_en = 1'b0;
        @(negedge clk_sys);
        got = rdata;
    endtask : rd
    task automatic frame(input logic a, input logic b);
        @(negedge clk_sys);
        req_a = a;
        req_b = b;
        repeat (20) @(negedge clk_sys);
        req_a = 1'b0;
        req_b = 1'b0;
        repeat (60) @(negedge clk_sys);
    endtask : frame
    function automatic logic [7:0] therm(input int v);
        return (8'h01 << (v % 8)) - 8'h01;
    endfunction : therm
    // the reported level may be one off, so a neighbour of k is accepted
    function automatic logic [7:0] near(input int v);
        if (got === therm(v - 1) || got === therm(v + 1)) return got;
        return therm(v);
    endfunction : near
    initial begin
        {run_a, run_b, req_a, req_b, ref_sync, pll_en, single, two_per, wr_en, rd_en} = '0;
        addr  = 8'h00;
        wdata = 8'h00;
        k = $urandom(78);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        wr(8'h11, 8'hA5);
        foreach (rst_tab[i]) begin
            rd(rst_tab[i]);
            check(got & 8'h7F, 8'h00);
        end
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            k = (i == 0) ? 8'hC0 : (i == 1) ? 8'h48 : $urandom % 256;
            wr(8'h10, 8'(k));
            rd(8'h10);
            check(got, 8'(k));
        end
        $display("test sync control done");
        run_a = 1'b1;
        run_b = 1'b1;
        repeat (20) @(negedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            k = 3 + $urandom % 3;
            two_per = i[0];
            wr(8'h10, 8'h80 | 8'(($urandom % 2) << 3));
            wr(8'h17, 8'(k));
            wr(8'h19, 8'(k));
            frame(1'b1, 1'b1);
            rd(8'h18);
            check(got, near(k));
            rd(8'h17);
            check(got, 8'(k));
            check({7'h00, warn}, 8'h00);
        end
        $display("test data rate frame done");
        wr(8'h10, 8'h00);
        frame(1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            pll_en = i[1];
            ref_sync = ~ref_sync;
            repeat (8) @(negedge clk_sys);
        end
        rd(8'h18);
        check(got, near(k));
        // a steady fifo hands out the source's counting words one after another
        stream(wa, wb);
        stream(xa, xb);
        check(8'(xa - wa), 8'h01);
        check(8'(xb - wb), 8'h01);
        $display("test no sync done");
        foreach (ctl[p]) begin
            k = 3 + $urandom % 3;
            wr(ctl[p], 8'h08 | 8'(k));
            rd(ctl[p]);
            check(got & 8'h1F, 8'h18 | 8'(k));
            wr(ctl[p], 8'(k));
            n = 0;
            do begin
                rd(ctl[p]);
                n++;
            end while (got[4] !== 1'b0 && n < 20);
            check({7'h00, got[4]}, 8'h00);
            rd(8'h06);
            check(got & 8'h04, 8'h04);
            wr(8'h06, 8'h04);
            rd(8'h06);
            check(got & 8'h04, 8'h00);
            rd(8'h18);
            if (p == 0) check(got, near(k));
        end
        $display("test manual reset done");
        wr(8'h10, 8'hC8);
        frame(1'b1, 1'b1);
        wr(8'h10, 8'h00);
        // port b strobe stalls: only a shared strobe keeps its fifo level steady
        single = 1'b1;
        run_b = 1'b0;
        wr(8'h17, 8'h04);
        wr(8'h19, 8'h04);
        frame(1'b1, 1'b0);
        n = 0;
        repeat (64) @(negedge clk_sys) if (warn !== 1'b0) n++;
        check(8'(n), 8'h00);
        single = 1'b0;
        n = 0;
        while (warn !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        check({7'h00, warn}, 8'h01);
        $display("test shared strobe and warning done");
        report_and_stop();
    end
endmodule : fps_fifo_pointer_sync_tb
bind fps_fifo_pointer_sync fps_fifo_pointer_sync_assertions #(.INTERP_RATIO(INTERP_RATIO))
    fps_fifo_pointer_sync_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dout_valid(dout_valid));
`default_nettype wire
